//--- core/tacc_pkg.sv
// Types shared by the trigger and acquisition count block.
// Assumes the constants of tacc_regs.svh are included where needed.
package tacc_pkg;
  typedef logic [15:0] tacc_word_t;
  typedef logic [7:0]  tacc_level_t;
  typedef logic [5:0]  tacc_addr_t;
  typedef logic [2:0]  tacc_line_t;
endpackage

//--- core/tacc_regs.svh
// Register offsets, field positions and reset values of the trigger block.
// Assumes byte offsets within the module's backplane register space.
`ifndef TACC_REGS_SVH
`define TACC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TACC_OFF_CH2_LEVEL    6'h2a
`define TACC_OFF_CH3_LEVEL    6'h2c
`define TACC_OFF_CH4_LEVEL    6'h2e
`define TACC_OFF_PERIOD_HIGH  6'h30
`define TACC_OFF_PERIOD_LOW   6'h32
`define TACC_OFF_PRE_HIGH     6'h34
`define TACC_OFF_PRE_LOW      6'h36
`define TACC_OFF_COUNT_HIGH   6'h38
`define TACC_OFF_COUNT_LOW    6'h3a
`define TACC_OFF_TRIG_CTRL    6'h3c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TACC_LVL_MSB          15
`define TACC_LVL_LSB          8
`define TACC_LVL_DIR_BIT      0
`define TACC_TC_LINE_MSB      2
`define TACC_TC_LINE_LSB      0
`define TACC_TC_DIR_BIT       3
`define TACC_TC_LINE_EN_BIT   4
`define TACC_TC_FOLLOWER_BIT  5
`define TACC_TC_LEADER_BIT    6
`define TACC_TC_SOFT_BIT      7
`define TACC_TC_EDGE_BIT      8
`define TACC_TC_EXT_EN_BIT    9
`define TACC_TC_PAIR_MSB      11
`define TACC_TC_PAIR_LSB      10
`define TACC_TC_CMP_MSB       15
`define TACC_TC_CMP_LSB       12
`define TACC_LVL_KEEP_MASK    16'hff01

// ----------------------------------------------------------------------
// Write select positions
// ----------------------------------------------------------------------
`define TACC_SEL_CH2_LEVEL    0
`define TACC_SEL_CH3_LEVEL    1
`define TACC_SEL_CH4_LEVEL    2
`define TACC_SEL_PERIOD_HIGH  3
`define TACC_SEL_PERIOD_LOW   4
`define TACC_SEL_PRE_HIGH     5
`define TACC_SEL_PRE_LOW      6
`define TACC_SEL_COUNT_HIGH   7
`define TACC_SEL_COUNT_LOW    8
`define TACC_SEL_TRIG_CTRL    9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TACC_RST_WORD         16'h0000
`define TACC_RST_LEVEL        16'h0000
`define TACC_RST_CTRL         16'h0000
`define TACC_RST_LINES        8'hff

`endif

//--- core/tacc_trigger_ctrl.sv
// Trigger source selection, channel level comparators and acquisition
// length registers of a multi-channel digitizer.
// Assumes a 16-bit register port on the module clock; backplane lines and
// the front-panel trigger arrive asynchronously and are synchronised here.
//
// Summary of operation
// - Level registers hold signed threshold in 15:8.
// - Level bit 0 picks greater or less.
// - Period high byte in 7:0, rest zero.
// - Period low word register, LSB at 0.
// - Pre-trigger count may be zero.
// - Pre-trigger count: low word plus six bits.
// - Sample count includes pre-trigger, least one.
// - Sample count zero means continuous acquisition.
// - Sample count: low word plus six bits.
// - Bits 2:0 pick the backplane line.
// - Bit 3 sets selected line direction.
// - Bit 4 enables selected backplane line.
// - Bit 5 makes module a follower.
// - Bit 6 makes module a leader.
// - Bit 7 gives immediate software trigger.
// - Bit 8 selects rising or falling edge.
// - Bit 9 enables front-panel trigger input.
// - Bits 11:10 select leader/follower line pair.
// - Bits 15:12 enable channel level triggers.
`timescale 1ns/1ps
`include "tacc_regs.svh"

module tacc_trigger_ctrl
  import tacc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        reading_valid_in,
  input  wire logic [7:0]  ch2_reading_in,
  input  wire logic [7:0]  ch3_reading_in,
  input  wire logic [7:0]  ch4_reading_in,
  input  wire logic        ch1_level_hit_in,
  input  wire logic        ext_trigger_in,
  input  wire logic [7:0]  ttl_line_in,
  output logic      [7:0]  ttl_line_out,
  output logic      [7:0]  ttl_line_oe_out,
  output logic             trigger_out,
  output logic      [23:0] sample_period_out,
  output logic      [21:0] pretrigger_count_out,
  output logic      [21:0] sample_count_out,
  output logic             continuous_out
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Level register: 1 = reading below level, 0 = reading above level.
  function automatic logic level_hit(input tacc_word_t lvl,
                                     input tacc_level_t rdg);
    logic signed [7:0] l;
    logic signed [7:0] r;
    l = lvl[`TACC_LVL_MSB:`TACC_LVL_LSB];
    r = rdg;
    if (lvl[`TACC_LVL_DIR_BIT]) begin
      level_hit = (r < l);
    end else begin
      level_hit = (r > l);
    end
  endfunction

  // Line code 011 maps to line 6; codes 100 to 110 select no line.
  function automatic logic [7:0] line_onehot(input tacc_line_t code);
    logic [7:0] m;
    m = 8'h00;
    unique case (code)
      3'h0: m = 8'h01;
      3'h1: m = 8'h02;
      3'h2: m = 8'h04;
      3'h3: m = 8'h40;
      3'h7: m = 8'h80;
      default: m = 8'h00;
    endcase
    line_onehot = m;
  endfunction

  function automatic logic edge_seen(input logic now, input logic was,
                                     input logic rising);
    edge_seen = rising ? (now & ~was) : (~now & was);
  endfunction

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  // One-hot select of the register written this cycle. Every register
  // block keys off this single decode, so an unmapped offset is dropped
  // in one place and can never reach a register.
  function automatic logic [9:0] write_select(input logic       wr,
                                              input tacc_addr_t a);
    logic [9:0] s;
    s = 10'h000;
    if (wr) begin
      unique case (a)
        `TACC_OFF_CH2_LEVEL:   s[`TACC_SEL_CH2_LEVEL] = 1'b1;
        `TACC_OFF_CH3_LEVEL:   s[`TACC_SEL_CH3_LEVEL] = 1'b1;
        `TACC_OFF_CH4_LEVEL:   s[`TACC_SEL_CH4_LEVEL] = 1'b1;
        `TACC_OFF_PERIOD_HIGH: s[`TACC_SEL_PERIOD_HIGH] = 1'b1;
        `TACC_OFF_PERIOD_LOW:  s[`TACC_SEL_PERIOD_LOW] = 1'b1;
        `TACC_OFF_PRE_HIGH:    s[`TACC_SEL_PRE_HIGH] = 1'b1;
        `TACC_OFF_PRE_LOW:     s[`TACC_SEL_PRE_LOW] = 1'b1;
        `TACC_OFF_COUNT_HIGH:  s[`TACC_SEL_COUNT_HIGH] = 1'b1;
        `TACC_OFF_COUNT_LOW:   s[`TACC_SEL_COUNT_LOW] = 1'b1;
        `TACC_OFF_TRIG_CTRL:   s[`TACC_SEL_TRIG_CTRL] = 1'b1;
        default:               s = 10'h000;
      endcase
    end
    write_select = s;
  endfunction

  logic [9:0] wsel;

  assign wsel = write_select(reg_wr_in, reg_addr_in);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  tacc_word_t  lvl2_q;
  tacc_word_t  lvl3_q;
  tacc_word_t  lvl4_q;
  logic [7:0]  period_hi_q;
  tacc_word_t  period_lo_q;
  logic [5:0]  pre_hi_q;
  tacc_word_t  pre_lo_q;
  logic [5:0]  count_hi_q;
  tacc_word_t  count_lo_q;
  tacc_word_t  ctrl_q;
  logic        soft_fire_q;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      lvl2_q <= `TACC_RST_LEVEL;
      lvl3_q <= `TACC_RST_LEVEL;
      lvl4_q <= `TACC_RST_LEVEL;
    end else begin
      // Bits 7 to 1 are fixed zero so they never store.
      if (wsel[`TACC_SEL_CH2_LEVEL]) begin
        lvl2_q <= reg_wdata_in & `TACC_LVL_KEEP_MASK;
      end
      if (wsel[`TACC_SEL_CH3_LEVEL]) begin
        lvl3_q <= reg_wdata_in & `TACC_LVL_KEEP_MASK;
      end
      if (wsel[`TACC_SEL_CH4_LEVEL]) begin
        lvl4_q <= reg_wdata_in & `TACC_LVL_KEEP_MASK;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      period_hi_q <= 8'h00;
      period_lo_q <= `TACC_RST_WORD;
    end else begin
      if (wsel[`TACC_SEL_PERIOD_HIGH]) begin
        period_hi_q <= reg_wdata_in[7:0];
      end
      if (wsel[`TACC_SEL_PERIOD_LOW]) begin
        period_lo_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pre_hi_q <= 6'h00;
      pre_lo_q <= `TACC_RST_WORD;
    end else begin
      if (wsel[`TACC_SEL_PRE_HIGH]) begin
        pre_hi_q <= reg_wdata_in[5:0];
      end
      if (wsel[`TACC_SEL_PRE_LOW]) begin
        pre_lo_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      count_hi_q <= 6'h00;
      count_lo_q <= `TACC_RST_WORD;
    end else begin
      if (wsel[`TACC_SEL_COUNT_HIGH]) begin
        count_hi_q <= reg_wdata_in[5:0];
      end
      if (wsel[`TACC_SEL_COUNT_LOW]) begin
        count_lo_q <= reg_wdata_in;
      end
    end
  end

  // software trigger on write
  // The immediate trigger fires once per write that sets the bit, so a
  // bit left at one does not retrigger on every clock.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ctrl_q      <= `TACC_RST_CTRL;
      soft_fire_q <= 1'b0;
    end else begin
      soft_fire_q <= wsel[`TACC_SEL_TRIG_CTRL]
                     && reg_wdata_in[`TACC_TC_SOFT_BIT];
      if (wsel[`TACC_SEL_TRIG_CTRL]) begin
        ctrl_q <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `TACC_OFF_CH2_LEVEL:   reg_rdata_out <= lvl2_q;
        `TACC_OFF_CH3_LEVEL:   reg_rdata_out <= lvl3_q;
        `TACC_OFF_CH4_LEVEL:   reg_rdata_out <= lvl4_q;
        `TACC_OFF_PERIOD_HIGH: reg_rdata_out <= {8'h00, period_hi_q};
        `TACC_OFF_PERIOD_LOW:  reg_rdata_out <= period_lo_q;
        `TACC_OFF_PRE_HIGH:    reg_rdata_out <= {10'h000, pre_hi_q};
        `TACC_OFF_PRE_LOW:     reg_rdata_out <= pre_lo_q;
        `TACC_OFF_COUNT_HIGH:  reg_rdata_out <= {10'h000, count_hi_q};
        `TACC_OFF_COUNT_LOW:   reg_rdata_out <= count_lo_q;
        `TACC_OFF_TRIG_CTRL:   reg_rdata_out <= ctrl_q;
        default:               reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Acquisition length outputs
  // ----------------------------------------------------------------------
  // zero count runs continuously
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sample_period_out    <= 24'h000000;
      pretrigger_count_out <= 22'h000000;
      sample_count_out     <= 22'h000000;
      continuous_out       <= 1'b1;
    end else begin
      sample_period_out    <= {period_hi_q, period_lo_q};
      pretrigger_count_out <= {pre_hi_q, pre_lo_q};
      sample_count_out     <= {count_hi_q, count_lo_q};
      continuous_out       <= ({count_hi_q, count_lo_q} == 22'h000000);
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and edge history
  // ----------------------------------------------------------------------
  logic [7:0] ttl_s1_q;
  logic [7:0] ttl_s2_q;
  logic [7:0] ttl_prev_q;
  logic       ext_s1_q;
  logic       ext_s2_q;
  logic       ext_prev_q;

  // Each stage resets to the idle level of its pin, so the release of
  // reset never shows up as a false edge on a line or the front panel.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ttl_s1_q   <= `TACC_RST_LINES;
      ttl_s2_q   <= `TACC_RST_LINES;
      ttl_prev_q <= `TACC_RST_LINES;
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ttl_s1_q   <= ttl_line_in;
      ttl_s2_q   <= ttl_s1_q;
      ttl_prev_q <= ttl_s2_q;
      ext_s1_q   <= ext_trigger_in;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------------
  logic       rising;
  logic [7:0] sel_mask;
  logic [7:0] pair_mask;
  logic [3:0] ch_hit;
  logic       line_trig;
  logic       pair_trig;
  logic       ext_trig;
  logic       chan_trig;
  logic       any_trig;

  assign rising = ctrl_q[`TACC_TC_EDGE_BIT];

  assign sel_mask = line_onehot(ctrl_q[`TACC_TC_LINE_MSB:`TACC_TC_LINE_LSB]);

  // pair 0, 2, 4 or 6
  assign pair_mask = 8'h01 << {ctrl_q[`TACC_TC_PAIR_MSB:`TACC_TC_PAIR_LSB],
                               1'b0};

  assign ch_hit[0] = ch1_level_hit_in;
  assign ch_hit[1] = reading_valid_in && level_hit(lvl2_q, ch2_reading_in);
  assign ch_hit[2] = reading_valid_in && level_hit(lvl3_q, ch3_reading_in);
  assign ch_hit[3] = reading_valid_in && level_hit(lvl4_q, ch4_reading_in);

  assign chan_trig = |(ch_hit & ctrl_q[`TACC_TC_CMP_MSB:`TACC_TC_CMP_LSB]);

  assign line_trig = ctrl_q[`TACC_TC_LINE_EN_BIT]
                     && !ctrl_q[`TACC_TC_DIR_BIT]
                     && edge_seen(|(ttl_s2_q & sel_mask),
                                  |(ttl_prev_q & sel_mask), rising);

  assign pair_trig = ctrl_q[`TACC_TC_FOLLOWER_BIT]
                     && edge_seen(|(ttl_s2_q & pair_mask),
                                  |(ttl_prev_q & pair_mask), rising);

  assign ext_trig = ctrl_q[`TACC_TC_EXT_EN_BIT]
                    && edge_seen(ext_s2_q, ext_prev_q, rising);

  assign any_trig = soft_fire_q | chan_trig | line_trig | pair_trig |
                    ext_trig;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      trigger_out <= 1'b0;
    end else begin
      trigger_out <= any_trig;
    end
  end

  // ----------------------------------------------------------------------
  // Backplane drive
  // ----------------------------------------------------------------------
  // Lines are open collector: a trigger pulls the line low for one cycle.
  // A module set as leader and follower at once hears its own drive on
  // the pair line and fires again, so software sets only one of the two.
  // drive out and leader
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ttl_line_oe_out <= 8'h00;
    end else begin
      ttl_line_oe_out <=
        ({8{any_trig && ctrl_q[`TACC_TC_LINE_EN_BIT]
            && ctrl_q[`TACC_TC_DIR_BIT]}} & sel_mask) |
        ({8{any_trig && ctrl_q[`TACC_TC_LEADER_BIT]}} & pair_mask);
    end
  end

  assign ttl_line_out = 8'h00;

endmodule

//--- dv/tacc_backplane_model.sv
// Backplane trigger lines as open-collector wires with pull-ups.
// Assumes the block drives its drive value wherever its enable is high.
`timescale 1ns/1ps
module tacc_backplane_model (
  input  wire logic [7:0] dut_drive_in,
  input  wire logic [7:0] dut_oe_in,
  input  wire logic [7:0] peer_pull_in,
  output logic      [7:0] line_out
);
  // A released line floats back high, so no stale value is ever seen.
  // wire level
  assign line_out = ~((dut_oe_in & ~dut_drive_in) | peer_pull_in);
endmodule

//--- dv/tacc_trigger_ctrl_props.sv
// Concurrent checks on the ports of the trigger and count block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module tacc_trigger_ctrl_props (
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic [5:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [7:0]  ttl_line_out,
  input wire logic [7:0]  ttl_line_oe_out,
  input wire logic        trigger_out,
  input wire logic [23:0] sample_period_out,
  input wire logic [21:0] pretrigger_count_out,
  input wire logic [21:0] sample_count_out,
  input wire logic        continuous_out
);
  wire logic [5:0] wdata_low = reg_wdata_in[5:0];
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  rd_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  lvl_zero_a: assert property (
    reg_rd_in && reg_addr_in == 6'h2a |=> reg_rdata_out[7:1] == 7'h00)
    else $error("level register spare bits not zero");
  per_high_a: assert property (
    reg_rd_in && reg_addr_in == 6'h30 |=> reg_rdata_out[15:8] == 8'h00)
    else $error("period high byte upper bits not zero");
  cnt_high_a: assert property (
    reg_rd_in && reg_addr_in == 6'h38 |=> reg_rdata_out[15:6] == 10'h000)
    else $error("count high upper bits not zero");
  per_low_a: assert property (
    reg_wr_in && reg_addr_in == 6'h32 |-> ##2
    sample_period_out[15:0] == $past(reg_wdata_in, 2))
    else $error("period low word not applied");
  pre_high_a: assert property (
    reg_wr_in && reg_addr_in == 6'h34 |-> ##2
    pretrigger_count_out[21:16] == $past(wdata_low, 2))
    else $error("pre-trigger high bits not applied");
  cont_flag_a: assert property (
    continuous_out == (sample_count_out == 22'h000000))
    else $error("continuous flag disagrees with count");
  soft_fire_a: assert property (
    reg_wr_in && reg_addr_in == 6'h3c && reg_wdata_in[7] |-> ##2 trigger_out)
    else $error("software trigger missing");
  oe_trig_a: assert property (ttl_line_oe_out != 8'h00 |-> trigger_out)
    else $error("line driven without a trigger");
  drive_low_a: assert property (ttl_line_out == 8'h00)
    else $error("line drive value not low");
  cover property (trigger_out);
  cover property ($fell(continuous_out));
  cover property (ttl_line_oe_out != 8'h00);
endmodule

bind tacc_trigger_ctrl tacc_trigger_ctrl_props u_props (.*);

//--- dv/tacc_trigger_ctrl_tb.sv
// Self-checking bench for the trigger and acquisition count block.
// Assumes the register port timing given with the block.
`timescale 1ns/1ps
module tacc_trigger_ctrl_tb;
  import tacc_pkg::*;
  logic        clock_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        wr, rd, vld, hit1, ext, trig, cont;
  tacc_addr_t  addr;
  tacc_word_t  wdata, rdata;
  tacc_level_t rdg;
  logic [7:0]  ln_in, ln_out, ln_oe, pull, oe_seen;
  logic [23:0] period;
  logic [21:0] pre, cnt;
  int          fails = 0, total_checks = 0, n;
  tacc_addr_t  ta [10] = '{6'h2a, 6'h2c, 6'h2e, 6'h30, 6'h32, 6'h34, 6'h36,
                           6'h38, 6'h3a, 6'h00};
  tacc_word_t  tw [10] = '{16'hffff, 16'h8000, 16'h7f01, 16'hab12, 16'h3457,
                           16'hff05, 16'h8001, 16'hffea, 16'h0000, 16'hffff};
  tacc_word_t  tr [10] = '{16'hff01, 16'h8000, 16'h7f01, 16'h0012, 16'h3457,
                           16'h0005, 16'h8001, 16'h002a, 16'h0000, 16'h0000};
  logic [2:0]  lcode [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int          lnum [5] = '{0, 1, 2, 6, 7};

  always #4 clock_in = ~clock_in;

  tacc_trigger_ctrl dut (
    .clock_in             (clock_in),
    .rstn_in              (rstn_in),
    .reg_addr_in          (addr),
    .reg_wr_in            (wr),
    .reg_rd_in            (rd),
    .reg_wdata_in         (wdata),
    .reg_rdata_out        (rdata),
    .reading_valid_in     (vld),
    .ch2_reading_in       (rdg),
    .ch3_reading_in       (rdg),
    .ch4_reading_in       (rdg),
    .ch1_level_hit_in     (hit1),
    .ext_trigger_in       (ext),
    .ttl_line_in          (ln_in),
    .ttl_line_out         (ln_out),
    .ttl_line_oe_out      (ln_oe),
    .trigger_out          (trig),
    .sample_period_out    (period),
    .pretrigger_count_out (pre),
    .sample_count_out     (cnt),
    .continuous_out       (cont)
  );
  tacc_backplane_model u_bp (
    .dut_drive_in (ln_out),
    .dut_oe_in    (ln_oe),
    .peer_pull_in (pull),
    .line_out     (ln_in)
  );

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input tacc_addr_t a, input tacc_word_t d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input tacc_addr_t a, input tacc_word_t exp);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 check(rdata, exp, "read");
  endtask
  // Samples once per cycle so a one-cycle pulse is counted exactly once.
  task automatic watch(input int exp_n, input logic [7:0] exp_oe);
    n = 0;
    oe_seen = 8'h00;
    repeat (8) begin
      #1;
      if (trig === 1'b1) n++;
      oe_seen = oe_seen | ln_oe;
      @(posedge clock_in);
    end
    check(24'(n), 24'(exp_n), "pulses");
    check(oe_seen, exp_oe, "drive");
  endtask
  task automatic pin(input logic e, input logic [7:0] p, input int exp_n);
    @(posedge clock_in);
    ext <= e;
    pull <= p;
    watch(exp_n, 8'h00);
  endtask
  task automatic src(input logic h, input tacc_level_t v, input int exp_n);
    @(posedge clock_in);
    hit1 <= h;
    rdg <= v;
    vld <= 1'b1;
    @(posedge clock_in);
    hit1 <= 1'b0;
    vld <= 1'b0;
    watch(exp_n, 8'h00);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {wr, rd, vld, hit1, ext} = 5'h00;
    addr = 6'h00;
    wdata = 16'h0000;
    rdg = 8'h00;
    pull = 8'h00;
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    #1 check(cont, 24'h000001, "cont");
    for (int i = 0; i < 10; i++) rd_reg(ta[i], 16'h0000);
    for (int i = 0; i < 10; i++) wr_reg(ta[i], tw[i]);
    for (int i = 0; i < 10; i++) rd_reg(ta[i], tr[i]);
    #1 check(period, 24'h123457, "period");
    check(pre, 24'h058001, "pre");
    check(cnt, 24'h2a0000, "count");
    check(cont, 24'h000000, "cont");
    // Counts stay small so they respect any memory size.
    wr_reg(6'h34, 16'h0000);
    wr_reg(6'h36, 16'h0000);
    wr_reg(6'h38, 16'h0000);
    wr_reg(6'h3a, 16'h0001);
    repeat (2) @(posedge clock_in);
    #1 check(pre, 24'h000000, "pre");
    check(cnt, 24'h000001, "count");
    check(cont, 24'h000000, "cont");
    $display("test registers done");
    for (int c = 0; c < 3; c++) wr_reg(6'h2a + 6'(2 * c), 16'h1000);
    src(1'b0, 8'h11, 0);
    for (int c = 1; c < 4; c++) begin
      wr_reg(6'h3c, 16'h1000 << c);
      src(1'b0, 8'h11, 1);
      src(1'b0, 8'h10, 0);
    end
    wr_reg(6'h3c, 16'h1000);
    src(1'b1, 8'h00, 1);
    wr_reg(6'h2a, 16'hf001);
    wr_reg(6'h3c, 16'h2000);
    src(1'b0, 8'hef, 1);
    src(1'b0, 8'h10, 0);
    $display("test comparators done");
    wr_reg(6'h3c, 16'h0080);
    watch(1, 8'h00);
    rd_reg(6'h3c, 16'h0080);
    wr_reg(6'h3c, 16'h0300);
    pin(1'b1, 8'h00, 1);
    pin(1'b0, 8'h00, 0);
    wr_reg(6'h3c, 16'h0200);
    pin(1'b1, 8'h00, 0);
    pin(1'b0, 8'h00, 1);
    wr_reg(6'h3c, 16'h0100);
    pin(1'b1, 8'h00, 0);
    $display("test soft and external done");
    for (int i = 0; i < 5; i++) begin
      wr_reg(6'h3c, 16'h0010 | 16'(lcode[i]));
      pin(1'b0, 8'h01 << lnum[i], 1);
      pin(1'b0, 8'h00, 0);
      wr_reg(6'h3c, 16'h0098 | 16'(lcode[i]));
      watch(1, 8'h01 << lnum[i]);
    end
    wr_reg(6'h3c, 16'h0000);
    pin(1'b0, 8'h01, 0);
    pin(1'b0, 8'h00, 0);
    for (int p = 0; p < 4; p++) begin
      wr_reg(6'h3c, 16'h00c0 | 16'(p << 10));
      watch(1, 8'h01 << (2 * p));
      wr_reg(6'h3c, 16'h0020 | 16'(p << 10));
      pin(1'b0, 8'h01 << (2 * p), 1);
      pin(1'b0, 8'h00, 0);
    end
    $display("test backplane lines done");
    wrap_up();
  end
endmodule
